// ### hw/tws_pkg.sv
// Shared constants and types for the two-wire register slave
package tws_pkg;

  // ************************************************************
  // Bus addressing and sizes
  // ************************************************************
  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 4;
  localparam int          NUM_REGS     = 16;
  localparam int          STRAP_W      = 3;
  localparam logic [3:0]  DEV_ID_HI    = 4'h7;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  CNT_ZERO     = 4'h0;
  localparam logic [3:0]  CNT_ONE      = 4'h1;

  // ************************************************************
  // Register file contents
  // ************************************************************
  // Addresses 0..6 read-only; constant values are arbitrary
  localparam logic [NUM_REGS-1:0] RO_MASK = 16'h007F;
  localparam logic [NUM_REGS-1:0][DATA_W-1:0] RO_VALUE = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h5A, 8'h3C, 8'h00, 8'hA5, 8'h11, 8'h22, 8'h33};
  localparam logic [DATA_W-1:0] RW_RESET = 8'h00;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_DEV     = 4'b0001,
    ST_DEV_ACK = 4'b0010,
    ST_REG     = 4'b0011,
    ST_REG_ACK = 4'b0100,
    ST_WR      = 4'b0101,
    ST_WR_ACK  = 4'b0110,
    ST_RD      = 4'b0111,
    ST_RD_ACK  = 4'b1000,
    ST_IGNORE  = 4'b1001
  } tws_state_type;

  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } tws_wr_type;

  typedef struct packed {
    logic [STRAP_W-1:0] strap_s1;
    logic [STRAP_W-1:0] strap_s2;
    logic               scl_s1;
    logic               scl_s2;
    logic               scl_p;
    logic               sda_s1;
    logic               sda_s2;
    logic               sda_p;
    tws_state_type      state;
    logic [DATA_W-1:0]  shift;
    logic [DATA_W-1:0]  tx;
    logic [3:0]         cnt;
    logic               rw;
    logic [ADDR_W-1:0]  ptr;
    logic               oe_n;
    logic               addressed;
    tws_wr_type         wr;
  } tws_slave_type;

  localparam tws_slave_type SLAVE_RESET = '{
    strap_s1: '0, strap_s2: '0, scl_s1: 1'b1, scl_s2: 1'b1, scl_p: 1'b1,
    sda_s1: 1'b1, sda_s2: 1'b1, sda_p: 1'b1, state: ST_IDLE,
    shift: '0, tx: '0, cnt: CNT_ZERO, rw: 1'b0, ptr: '0,
    oe_n: 1'b1, addressed: 1'b0, wr: '0};

endpackage

// ### hw/tws_regfile.sv
// Sixteen byte configuration store with read-only constants
`timescale 1ns/100ps
module tws_regfile
  import tws_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Write side
  input  wire tws_pkg::tws_wr_type   wr,
  // Read side
  input  wire logic [tws_pkg::ADDR_W-1:0] rd_addr,
  output logic [tws_pkg::DATA_W-1:0] rd_data
);

  typedef struct packed {
    logic [NUM_REGS-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0]               rd;
  } tws_mem_type;

  tws_mem_type s_r;
  tws_mem_type s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    // Read-only slots keep their value even when written
    if (wr.we && !RO_MASK[wr.addr])                                     // [RULE_13]
    begin
      s_nxt.mem[wr.addr] = wr.data;
    end
    s_nxt.rd = RO_MASK[rd_addr] ? RO_VALUE[rd_addr] : s_r.mem[rd_addr];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_r.mem <= {NUM_REGS{RW_RESET}};
      s_r.rd  <= RW_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign rd_data = s_r.rd;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_ro_kept;
    RO_MASK[rd_addr] |=> rd_data == RO_VALUE[$past(rd_addr)];
  endproperty
  a_ro_kept: assert property (p_ro_kept) else $error("read-only byte changed"); // [RULE_13]

endmodule

// ### hw/tws_slave.sv
// Two-wire serial slave giving byte access to configuration registers
`timescale 1ns/100ps
// How it works
// [RULE_01] Advances only on master's clock/data transitions
// [RULE_02] One data byte per transfer, no paging
// [RULE_03] Address is 0111 plus three strap pins
// [RULE_04] Start, address with write bit, first ack
// [RULE_05] Register address byte latched, second ack
// [RULE_06] Repeated start, address with read, third ack
// [RULE_07] Drive selected byte, then release the line
// [RULE_08] Write byte stored at latched address, acked
// [RULE_09] Bytes travel most significant bit first
// [RULE_10] Ack or nack after read both accepted
// [RULE_11] Plain read returns previously latched address
// [RULE_12] Foreign address ignored until next start
// [RULE_13] Writes to read-only registers change nothing
module tws_slave
  import tws_pkg::*;
(
  // Clock and reset
  input  wire logic                         CLK,
  input  wire logic                         RESET,
  // Serial bus pins
  input  wire logic                         SCL,
  input  wire logic                         SDA_IN,
  output logic                              SDA_OUT,
  output logic                              SDA_OE_N,
  // Straps and status
  input  wire logic [tws_pkg::STRAP_W-1:0]  SLAVE_ADDRESS_STRAP_PINS,
  output logic                              ADDRESSED
);

  tws_slave_type s_r;
  tws_slave_type s_nxt;
  logic [DATA_W-1:0] rd_data;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic byte_done;
  logic addr_match;

  // ************************************************************
  // Register store
  // ************************************************************
  tws_regfile u_regs
  (
    .clk     (CLK),
    .reset   (RESET),
    .wr      (s_r.wr),
    .rd_addr (s_r.ptr),
    .rd_data (rd_data)
  );

  // ************************************************************
  // Bus edge detection
  // ************************************************************
  // Edges come only from the second sync stage, never the first
  assign scl_rise   = s_r.scl_s2 & ~s_r.scl_p;                           // [RULE_01]
  assign scl_fall   = ~s_r.scl_s2 & s_r.scl_p;                           // [RULE_01]
  assign start_cond = s_r.scl_s2 & s_r.scl_p & s_r.sda_p & ~s_r.sda_s2;
  assign stop_cond  = s_r.scl_s2 & s_r.scl_p & ~s_r.sda_p & s_r.sda_s2;
  assign byte_done  = scl_fall && (s_r.cnt == BITS_PER_BYTE);
  assign addr_match = s_r.shift[DATA_W-1:1] == {DEV_ID_HI, s_r.strap_s2}; // [RULE_03]

  // ************************************************************
  // Protocol state machine
  // ************************************************************
  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.wr.we    = 1'b0;
    s_nxt.strap_s1 = SLAVE_ADDRESS_STRAP_PINS;
    s_nxt.strap_s2 = s_r.strap_s1;
    s_nxt.scl_s1   = SCL;
    s_nxt.scl_s2   = s_r.scl_s1;
    s_nxt.scl_p    = s_r.scl_s2;
    s_nxt.sda_s1   = SDA_IN;
    s_nxt.sda_s2   = s_r.sda_s1;
    s_nxt.sda_p    = s_r.sda_s2;

    if (scl_rise)
    begin
      s_nxt.shift = {s_r.shift[DATA_W-2:0], s_r.sda_s2};                 // [RULE_09]
      s_nxt.cnt   = s_r.cnt + CNT_ONE;
    end

    if (stop_cond)
    begin
      s_nxt.state     = ST_IDLE;
      s_nxt.oe_n      = 1'b1;
      s_nxt.addressed = 1'b0;
    end
    else if (start_cond)
    begin
      // Repeated start lands here too; pointer is kept
      s_nxt.state = ST_DEV;                                              // [RULE_04]
      s_nxt.cnt   = CNT_ZERO;
      s_nxt.oe_n  = 1'b1;
    end
    else
    begin
      case (s_r.state)
        ST_DEV:
        begin
          if (byte_done)
          begin
            if (addr_match)
            begin
              s_nxt.state     = ST_DEV_ACK;                              // [RULE_04]
              s_nxt.oe_n      = 1'b0;
              s_nxt.rw        = s_r.shift[0];
              s_nxt.addressed = 1'b1;
            end
            else
            begin
              s_nxt.state = ST_IGNORE;                                   // [RULE_12]
            end
          end
        end
        ST_DEV_ACK:
        begin
          if (scl_fall)
          begin
            s_nxt.cnt = CNT_ZERO;
            if (s_r.rw)
            begin
              // Pointer from an earlier transfer serves a plain read
              s_nxt.state = ST_RD;                                       // [RULE_06] [RULE_11]
              s_nxt.oe_n  = rd_data[DATA_W-1];                           // [RULE_09]
              s_nxt.tx    = {rd_data[DATA_W-2:0], 1'b0};
            end
            else
            begin
              s_nxt.state = ST_REG;
              s_nxt.oe_n  = 1'b1;
            end
          end
        end
        ST_REG:
        begin
          if (byte_done)
          begin
            // Upper address bits ignored: only sixteen slots exist
            s_nxt.ptr   = s_r.shift[ADDR_W-1:0];                         // [RULE_05]
            s_nxt.state = ST_REG_ACK;
            s_nxt.oe_n  = 1'b0;
          end
        end
        ST_REG_ACK:
        begin
          if (scl_fall)
          begin
            s_nxt.state = ST_WR;
            s_nxt.cnt   = CNT_ZERO;
            s_nxt.oe_n  = 1'b1;
          end
        end
        ST_WR:
        begin
          if (byte_done)
          begin
            s_nxt.wr.we   = 1'b1;                                        // [RULE_08]
            s_nxt.wr.addr = s_r.ptr;
            s_nxt.wr.data = s_r.shift;
            s_nxt.state   = ST_WR_ACK;
            s_nxt.oe_n    = 1'b0;
          end
        end
        ST_WR_ACK:
        begin
          if (scl_fall)
          begin
            // No page mode: later bytes go unanswered
            s_nxt.state = ST_IGNORE;                                     // [RULE_02]
            s_nxt.oe_n  = 1'b1;
          end
        end
        ST_RD:
        begin
          if (byte_done)
          begin
            s_nxt.state = ST_RD_ACK;                                     // [RULE_07]
            s_nxt.oe_n  = 1'b1;
          end
          else if (scl_fall)
          begin
            s_nxt.oe_n = s_r.tx[DATA_W-1];                               // [RULE_09]
            s_nxt.tx   = {s_r.tx[DATA_W-2:0], 1'b0};
          end
        end
        ST_RD_ACK:
        begin
          // Ack and nack treated alike; single byte either way
          if (scl_rise)
          begin
            s_nxt.state = ST_IGNORE;                                     // [RULE_10] [RULE_02]
          end
        end
        default:
        begin
          s_nxt.oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      s_r <= SLAVE_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Line is only ever pulled low, never driven high
  assign SDA_OUT   = 1'b0;
  assign SDA_OE_N  = s_r.oe_n;
  assign ADDRESSED = s_r.addressed;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_addr_byte;
    s_r.state == ST_DEV && byte_done && !start_cond && !stop_cond;
  endsequence

  sequence s_plain;
    !start_cond && !stop_cond;
  endsequence

  property p_addr_ack;
    s_addr_byte ##0 addr_match |=> !SDA_OE_N && s_r.state == ST_DEV_ACK;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acked"); // [RULE_04]

  property p_addr_nomatch;
    s_addr_byte ##0 !addr_match |=> SDA_OE_N && s_r.state == ST_IGNORE;
  endproperty
  a_addr_nomatch: assert property (p_addr_nomatch) else $error("foreign address acked"); // [RULE_12]

  property p_hi_nibble;
    s_addr_byte ##0 (s_r.shift[DATA_W-1:4] != DEV_ID_HI) |=> s_r.state == ST_IGNORE;
  endproperty
  a_hi_nibble: assert property (p_hi_nibble) else $error("fixed nibble not checked"); // [RULE_03]

  property p_reg_latch;
    (s_r.state == ST_REG && byte_done) and s_plain
      |=> s_r.ptr == $past(s_r.shift[ADDR_W-1:0]) && !SDA_OE_N;
  endproperty
  a_reg_latch: assert property (p_reg_latch) else $error("register address not latched"); // [RULE_05]

  property p_write;
    (s_r.state == ST_WR && byte_done) and s_plain
      |=> s_r.wr.we && s_r.wr.data == $past(s_r.shift) && !SDA_OE_N ##1 !s_r.wr.we;
  endproperty
  a_write: assert property (p_write) else $error("write byte not stored"); // [RULE_08]

  property p_single;
    (s_r.state == ST_WR_ACK && scl_fall) and s_plain |=> s_r.state == ST_IGNORE && SDA_OE_N;
  endproperty
  a_single: assert property (p_single) else $error("second byte accepted"); // [RULE_02]

  property p_rd_first;
    (s_r.state == ST_DEV_ACK && s_r.rw && scl_fall) and s_plain
      |=> s_r.state == ST_RD && SDA_OE_N == $past(rd_data[DATA_W-1]);
  endproperty
  a_rd_first: assert property (p_rd_first) else $error("read not msb first"); // [RULE_09]

  property p_rd_release;
    (s_r.state == ST_RD && byte_done) and s_plain |=> SDA_OE_N && s_r.state == ST_RD_ACK;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("line held after read"); // [RULE_07]

  property p_nack_ok;
    (s_r.state == ST_RD_ACK && scl_rise) and s_plain |=> s_r.state == ST_IGNORE;
  endproperty
  a_nack_ok: assert property (p_nack_ok) else $error("master answer mishandled"); // [RULE_10]

  property p_no_edge_still;
    s_r.scl_s2 == s_r.scl_p && s_r.sda_s2 == s_r.sda_p |=> $stable(s_r.state);
  endproperty
  a_no_edge_still: assert property (p_no_edge_still) else $error("moved without bus edge"); // [RULE_01]

endmodule

// ### sim/tws_master.sv
// Behavioural two-wire bus master for the slave bench
`timescale 1ns/100ps
module tws_master
(
  // System clock for pacing
  input  wire logic clk,
  // Bus wire level and drives
  input  wire logic sda,
  output logic      scl,
  output logic      sda_lo
);
  // ************
  // Bus idle
  // ************
  // Serial clock stands high between frames, data released
  initial
  begin
    scl    = 1'b1;
    sda_lo = 1'b0;
  end

  // ************
  // Bus steps
  // ************
  task automatic q(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Data set mid-low, sampled mid-high: 4 clocks high, 4 low
  task automatic bit_io(input logic b, output logic r);
    sda_lo = ~b;
    q(2);
    scl = 1'b1;
    q(2);
    r = sda;
    q(2);
    scl = 1'b0;
    q(2);
  endtask

  task automatic start();
    sda_lo = 1'b0;
    q(2);
    scl = 1'b1;
    q(2);
    sda_lo = 1'b1;
    q(2);
    scl = 1'b0;
    q(2);
  endtask

  task automatic stop();
    sda_lo = 1'b1;
    q(2);
    scl = 1'b1;
    q(2);
    sda_lo = 1'b0;
    q(4);
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic rbyte(output logic [7:0] b, input logic nak);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(nak, r);
  endtask
endmodule

// ### sim/two_wire_register_slave_test.sv
// Self-checking bench for the two-wire register slave
`timescale 1ns/100ps
module two_wire_register_slave_test;
  import tws_pkg::*;
  logic                 CLK    = 1'b0;
  logic                 RESET  = 1'b1;
  logic [STRAP_W-1:0]   straps = '0;
  logic                 scl;
  logic                 sda_lo;
  logic                 sda_out;
  logic                 sda_oe_n;
  logic                 addressed;
  logic                 sda_w;
  logic [31:0]          seed   = 32'h37DD;
  logic [7:0]           mdl [NUM_REGS];
  int                   num_errors = 0;
  int                   n_checks   = 0;

  // Pull-up wire; an unknown slave enable reads as released (high)
  assign sda_w = sda_lo ? 1'b0 : ((sda_oe_n === 1'b0) ? sda_out : 1'b1);

  always #12.5 CLK = ~CLK;

  tws_slave i_dut
  (
    .CLK                      (CLK),
    .RESET                    (RESET),
    .SCL                      (scl),
    .SDA_IN                   (sda_w),
    .SDA_OUT                  (sda_out),
    .SDA_OE_N                 (sda_oe_n),
    .SLAVE_ADDRESS_STRAP_PINS (straps),
    .ADDRESSED                (addressed)
  );

  tws_master i_mst
  (
    .clk    (CLK),
    .sda    (sda_w),
    .scl    (scl),
    .sda_lo (sda_lo)
  );

  // ************
  // Helpers
  // ************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] dev(input logic rw);
    return {DEV_ID_HI, straps, rw};
  endfunction

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask

  task automatic ackb(input string nm, input logic [7:0] b, input logic exp);
    logic a;
    i_mst.wbyte(b, a);
    chk(nm, {7'h00, exp}, {7'h00, a});
  endtask

  task automatic wr(input logic [3:0] ra, input logic [7:0] d, input logic page);
    i_mst.start();
    ackb("dev_ack", dev(1'b0), 1'b1);
    chk("addressed", 8'h01, {7'h00, addressed});
    ackb("reg_ack", {4'h0, ra}, 1'b1);
    ackb("wr_ack", d, 1'b1);
    if (page)
      ackb("page_ack", ~d, 1'b0);
    i_mst.stop();
    chk("addressed_end", 8'h00, {7'h00, addressed});
    // Read-only places keep their constants
    if (!RO_MASK[ra])
      mdl[ra] = d;
  endtask

  task automatic rd(input logic [3:0] ra, input logic nak, input logic short_rd);
    logic [7:0] got;
    i_mst.start();
    if (!short_rd)
    begin
      ackb("rd_dev0_ack", dev(1'b0), 1'b1);
      ackb("rd_reg_ack", {4'h0, ra}, 1'b1);
      i_mst.start();
    end
    ackb("rd_dev1_ack", dev(1'b1), 1'b1);
    i_mst.rbyte(got, nak);
    i_mst.stop();
    chk("rd_data", mdl[ra], got);
  endtask

  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ************
  // Main sequence
  // ************
  initial
  begin
    logic [3:0] ra;
    for (int i = 0; i < NUM_REGS; i++)
      mdl[i] = RO_MASK[i] ? RO_VALUE[i] : RW_RESET;
    repeat (12) @(negedge CLK);
    RESET = 1'b0;
    chk("oe_reset", 8'h01, {7'h00, sda_oe_n});
    repeat (40) @(negedge CLK);
    chk("oe_idle", 8'h01, {7'h00, sda_oe_n});
    for (int a = 0; a < 7; a++)
      rd(a[3:0], a[0], 1'b0);
    wr(4'h3, 8'hFF, 1'b0);
    rd(4'h3, 1'b1, 1'b0);
    wr(4'h8, 8'hC3, 1'b1);
    rd(4'h9, 1'b0, 1'b0);
    rd(4'h8, 1'b1, 1'b0);
    for (int i = 0; i < 24; i++)
    begin
      seed   = lfsr(seed);
      straps = seed[2:0];
      ra     = seed[11:8];
      repeat (4) @(negedge CLK);
      wr(ra, seed[23:16], 1'b0);
      rd(ra, seed[4], 1'b0);
      rd(ra, 1'b1, 1'b1);
    end
    // Wrong strap bits, then wrong fixed nibble
    for (int k = 0; k < 2; k++)
    begin
      i_mst.start();
      ackb("foreign", k ? {4'h6, straps, 1'b0} : {DEV_ID_HI, ~straps, 1'b0}, 1'b0);
      ackb("ignored", 8'h0A, 1'b0);
      chk("foreign_addr", 8'h00, {7'h00, addressed});
      i_mst.stop();
    end
    // Pointer must not have moved to the ignored byte
    rd(ra, 1'b1, 1'b1);
    report_and_stop();
  end

  // Expected run is about 0.53 ms
  initial
  begin
    #1_500_000;
    num_errors++;
    report_and_stop();
  end
endmodule
